/* hdl/rdls_link_if.sv */
// Link between the serializer and the display-side receiver
`timescale 1ns/1ps
interface rdls_link_if;
  logic [1:0] lane0_diff_out;
  logic [1:0] lane1_diff_out;
  logic [1:0] link_clock_diff_out;
  logic       cfg_port_select_n;
  logic       cfg_port_clk;
  logic       cfg_port_in;
  logic       sleep_request_n;
  logic       test_select;
  modport dev (output lane0_diff_out, lane1_diff_out, link_clock_diff_out,
               input cfg_port_select_n, cfg_port_clk, cfg_port_in,
               sleep_request_n, test_select);
  modport host (input lane0_diff_out, lane1_diff_out, link_clock_diff_out,
                output cfg_port_select_n, cfg_port_clk, cfg_port_in,
                sleep_request_n, test_select);
endinterface : rdls_link_if

/* hdl/rdls_pkg.sv */
// Shared constants for the display link serializer and its far end
package rdls_pkg;
  // Link word: mark, odd parity, then 27 data bits
  localparam int         DATA_W    = 27;
  localparam int         WORD_W    = 32;
  localparam int         LANE_BITS = 16;
  localparam logic [3:0] SEQ_MARK  = 4'ha;
  // Configuration frame: target, table index, data
  localparam int         CFG_W     = 18;
  localparam logic [1:0] TGT_CTRL  = 2'h0;
  localparam logic [1:0] TGT_RED   = 2'h1;
  localparam logic [1:0] TGT_GRN   = 2'h2;
  localparam logic [1:0] TGT_BLU   = 2'h3;
  localparam int         CTRL_TAB  = 0;
  localparam int         CTRL_DITH = 1;
  localparam int         CTRL_W18  = 2;
  localparam logic [2:0] CTRL_RST  = 3'h0;
  // Timing on the 25 MHz system clock
  localparam int CLK_MHZ     = 25;
  localparam int STOP_NS     = 2000;
  localparam int STOP_CYC    = (STOP_NS * CLK_MHZ) / 1000;
  localparam int LINK_HALF   = 2;
  localparam int LINK_GAP    = 8;
  localparam int RX_IDLE_CYC = 6;
  localparam int CFG_HALF    = 4;
  // Host register byte offsets and reset values
  localparam logic [4:0] A_CMD    = 5'h00;
  localparam logic [4:0] A_STATUS = 5'h04;
  localparam logic [4:0] A_ERRS   = 5'h08;
  localparam logic [4:0] A_PIXEL  = 5'h0c;
  localparam logic [4:0] A_POWER  = 5'h10;
  localparam logic [1:0] POWER_RST = 2'h1;
endpackage : rdls_pkg

/* hdl/rdls_receiver.sv */
// Display-side end: link receiver and configuration master
`timescale 1ns/1ps
module rdls_receiver
  import rdls_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic [26:0]      rx_pixel,
  output logic             rx_pixel_valid,
  rdls_link_if.host        link
);
  // Synchronise link clock and lanes (true legs)
  logic [2:0] ln_m_q;
  logic [2:0] ln_s_q;
  logic       lc_p_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {ln_m_q, ln_s_q, lc_p_q} <= 7'h0;
    end else begin
      ln_m_q <= {link.link_clock_diff_out[1], link.lane0_diff_out[1],
                 link.lane1_diff_out[1]};
      ln_s_q <= ln_m_q;
      lc_p_q <= ln_s_q[2];
    end
  end
  wire logic lc_rise = ln_s_q[2] & ~lc_p_q;

  // Shift both lanes; a quiet clock realigns the bit count
  logic [15:0] sh0_q;
  logic [15:0] sh1_q;
  logic [4:0]  bc_q;
  logic [3:0]  idle_q;
  wire  logic [15:0] sh0_d = {sh0_q[14:0], ln_s_q[1]};
  wire  logic [15:0] sh1_d = {sh1_q[14:0], ln_s_q[0]};
  wire  logic [31:0] rx_w = {sh0_d, sh1_d};
  wire  logic full = lc_rise & (bc_q == 5'(LANE_BITS - 1));
  wire  logic good = (rx_w[31:28] == SEQ_MARK) & (^rx_w[27:0]);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {sh0_q, sh1_q} <= '0;
      bc_q   <= '0;
      idle_q <= '0;
    end else if (lc_rise) begin
      sh0_q  <= sh0_d;
      sh1_q  <= sh1_d;
      bc_q   <= full ? 5'h0 : bc_q + 5'h1;
      idle_q <= '0;
    end else if (idle_q == 4'(RX_IDLE_CYC)) begin
      bc_q <= '0;
    end else begin
      idle_q <= idle_q + 4'h1;
    end
  end

  // Received pixel, lock flag and error count
  logic        lock_q;
  logic [15:0] errs_q;
  wire  logic  err_clr = write & (address == A_ERRS);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_pixel       <= '0;
      rx_pixel_valid <= 1'b0;
      lock_q         <= 1'b0;
      errs_q         <= '0;
    end else begin
      rx_pixel_valid <= full & good;
      if (full) lock_q <= good;
      if (full && good) rx_pixel <= rx_w[26:0];
      if (full && !good) errs_q <= errs_q + 16'h1;
      else if (err_clr) errs_q <= '0;
    end
  end

  // Configuration master: 18 bits MSB first, then select released
  logic [CFG_W-1:0] cmd_q;
  logic [CFG_W-1:0] csh_q;
  logic [4:0]       cbit_q;
  logic [3:0]       cph_q;
  logic             busy_q;
  logic [1:0]       power_q;
  wire  logic cmd_wr = write & (address == A_CMD) & ~busy_q;
  wire  logic cph_end = (cph_q == 4'(2 * CFG_HALF - 1));
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {cmd_q, csh_q} <= '0;
      {cbit_q, cph_q} <= '0;
      busy_q <= 1'b0;
    end else if (cmd_wr) begin
      cmd_q  <= writedata[CFG_W-1:0];
      csh_q  <= writedata[CFG_W-1:0];
      busy_q <= 1'b1;
      {cbit_q, cph_q} <= '0;
    end else if (busy_q) begin
      cph_q <= cph_end ? 4'h0 : cph_q + 4'h1;
      if (cph_end) begin
        cbit_q <= cbit_q + 5'h1;
        csh_q  <= {csh_q[CFG_W-2:0], 1'b0};
        if (cbit_q == 5'(CFG_W + 1)) busy_q <= 1'b0;
      end
    end
  end
  wire logic csel = busy_q & (cbit_q < 5'(CFG_W));
  assign link.cfg_port_select_n = ~csel;
  assign link.cfg_port_in       = csel & csh_q[CFG_W-1];
  assign link.cfg_port_clk      = csel & (cph_q >= 4'(CFG_HALF));
  assign link.sleep_request_n   = power_q[0];
  assign link.test_select       = power_q[1];

  // Avalon-MM slave: reads answer one cycle late, busy stalls commands
  logic rd_ack_q;
  wire  logic [31:0] rd_mux =
      (address == A_CMD)    ? {14'h0, cmd_q} :
      (address == A_STATUS) ? {30'h0, lock_q, busy_q} :
      (address == A_ERRS)   ? {16'h0, errs_q} :
      (address == A_PIXEL)  ? {5'h0, rx_pixel} :
      (address == A_POWER)  ? {30'h0, power_q} : 32'h0;
  assign waitrequest = (read & ~rd_ack_q)
                     | (write & (address == A_CMD) & busy_q);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_ack_q <= 1'b0;
      readdata <= '0;
      power_q  <= POWER_RST;
    end else begin
      rd_ack_q <= read & ~rd_ack_q;
      if (read && !rd_ack_q) readdata <= rd_mux;
      if (write && address == A_POWER) power_q <= writedata[1:0];
    end
  end
endmodule : rdls_receiver

/* hdl/rdls_serializer.sv */
// Pixel bus serializer: capture, colour tables, dither, two-lane link
// Operation
// - Power-down pin sleeps, resets config, keeps tables
// - Stopped pixel clock sleeps, keeps config and tables
// - Awake with running pixel clock serializes
// - Config accepted only when selected and awake
// - Capture bus on pixel clock rising edge
// - Bit 7 is each colour's MSB
// - 18-bit mode uses upper six bits
// - Frame sync restarts dither pattern
// - Frame sync forwarded unmodified
// - Dither reduces 24-bit to 18-bit colour
// - Three writable 256x8 colour tables
// - Two data lanes plus clock lane
// - Word carries colours, syncs and valid
// - Sequence mark and odd parity per word
// - Config port sets options, loads tables
// - Test select held low in normal use
`timescale 1ns/1ps
module rdls_serializer
  import rdls_pkg::*;
#(
  parameter int STOP_CYCLES = STOP_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       pixel_clk,
  input  wire logic [7:0] red_in,
  input  wire logic [7:0] green_in,
  input  wire logic [7:0] blue_in,
  input  wire logic       frame_sync,
  input  wire logic       line_sync,
  input  wire logic       pixel_valid,
  output logic            asleep,
  rdls_link_if.dev        link
);
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01,
    TX_GAP   = 2'b10
  } rdls_tx_t;

  // Two-stage synchronisers for every pin
  logic [32:0] pin_raw;
  logic [32:0] pin_m_q;
  logic [32:0] pin_s_q;
  assign pin_raw = {pixel_clk, link.cfg_port_select_n, link.cfg_port_clk,
                    link.cfg_port_in, link.sleep_request_n,
                    link.test_select, frame_sync, line_sync, pixel_valid,
                    red_in, green_in, blue_in};
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
    end
  end

  wire logic        pclk_s  = pin_s_q[32];
  wire logic        sel_n_s = pin_s_q[31];
  wire logic        cclk_s  = pin_s_q[30];
  wire logic        cin_s   = pin_s_q[29];
  wire logic        wake_s  = pin_s_q[28];
  wire logic        test_s  = pin_s_q[27];
  wire logic [26:0] video_s = pin_s_q[26:0];

  // Edge detection on synchronised clocks and select
  logic pclk_p_q;
  logic cclk_p_q;
  logic sel_p_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pclk_p_q <= 1'b0;
      cclk_p_q <= 1'b0;
      sel_p_q  <= 1'b1;
    end else begin
      pclk_p_q <= pclk_s;
      cclk_p_q <= cclk_s;
      sel_p_q  <= sel_n_s;
    end
  end
  wire logic pclk_rise = pclk_s & ~pclk_p_q;
  wire logic cclk_rise = cclk_s & ~cclk_p_q;
  wire logic sel_rise  = sel_n_s & ~sel_p_q;

  // Stopped pixel clock detection
  logic [15:0] stop_cnt_q;
  wire  logic  stopped = (stop_cnt_q >= 16'(STOP_CYCLES));
  always_ff @(posedge clk_sys) begin
    if (rst || pclk_rise)
      stop_cnt_q <= '0;
    else if (!stopped)
      stop_cnt_q <= stop_cnt_q + 16'h1;
  end

  // Power state; test mode also keeps the link quiet
  wire logic run = wake_s & ~stopped & ~test_s;
  assign asleep = ~run;

  // Configuration shift register, active only when awake and selected
  logic [CFG_W-1:0] cfg_sh_q;
  logic [4:0]       cfg_cnt_q;
  logic [2:0]       ctrl_q;
  wire  logic cfg_bit  = cclk_rise & ~sel_n_s & wake_s;
  wire  logic cfg_done = sel_rise & wake_s
                         & (cfg_cnt_q == 5'(CFG_W));
  wire  logic [1:0] cfg_tgt  = cfg_sh_q[17:16];
  wire  logic [7:0] cfg_idx  = cfg_sh_q[15:8];
  wire  logic [7:0] cfg_data = cfg_sh_q[7:0];
  always_ff @(posedge clk_sys) begin
    if (rst || sel_n_s) begin
      cfg_cnt_q <= '0;
    end else if (cfg_bit && cfg_cnt_q != 5'h1f) begin
      cfg_cnt_q <= cfg_cnt_q + 5'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst)
      cfg_sh_q <= '0;
    else if (cfg_bit)
      cfg_sh_q <= {cfg_sh_q[CFG_W-2:0], cin_s};
  end
  // Control register; power-down pin restores defaults
  always_ff @(posedge clk_sys) begin
    if (rst || !wake_s)
      ctrl_q <= CTRL_RST;
    else if (cfg_done && cfg_tgt == TGT_CTRL)
      ctrl_q <= cfg_data[2:0];
  end

  // Colour tables: no reset, so contents survive every sleep
  logic [7:0] red_tab [256];
  logic [7:0] grn_tab [256];
  logic [7:0] blu_tab [256];
  always_ff @(posedge clk_sys) begin
    if (cfg_done && cfg_tgt == TGT_RED)
      red_tab[cfg_idx] <= cfg_data;
    if (cfg_done && cfg_tgt == TGT_GRN)
      grn_tab[cfg_idx] <= cfg_data;
    if (cfg_done && cfg_tgt == TGT_BLU)
      blu_tab[cfg_idx] <= cfg_data;
  end

  // Capture stage on each pixel clock rising edge while run is set
  logic [26:0] cap_q;
  logic        cap_new_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cap_q     <= '0;
      cap_new_q <= 1'b0;
    end else begin
      cap_new_q <= pclk_rise & run;
      if (pclk_rise && run)
        cap_q <= video_s;
    end
  end
  // Bit 7 of each byte is the MSB
  wire logic [7:0] cap_r = cap_q[23:16];
  wire logic [7:0] cap_g = cap_q[15:8];
  wire logic [7:0] cap_b = cap_q[7:0];

  // Table lookup ahead of the dither
  wire logic       tab_en = ctrl_q[CTRL_TAB];
  wire logic [7:0] lut_r = tab_en ? red_tab[cap_r] : cap_r;
  wire logic [7:0] lut_g = tab_en ? grn_tab[cap_g] : cap_g;
  wire logic [7:0] lut_b = tab_en ? blu_tab[cap_b] : cap_b;

  // Dither phase: frame, line and pixel parity
  logic frm_par_q;
  logic lin_par_q;
  logic pix_par_q;
  logic vs_p_q;
  logic hs_p_q;
  wire  logic vs_rise = cap_new_q & cap_q[26] & ~vs_p_q;
  wire  logic hs_rise = cap_new_q & cap_q[25] & ~hs_p_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {frm_par_q, lin_par_q, pix_par_q} <= 3'h0;
      {vs_p_q, hs_p_q} <= 2'h0;
    end else if (cap_new_q) begin
      vs_p_q <= cap_q[26];
      hs_p_q <= cap_q[25];
      if (vs_rise) begin
        frm_par_q <= ~frm_par_q;
        lin_par_q <= 1'b0;
      end else if (hs_rise) begin
        lin_par_q <= ~lin_par_q;
      end
      pix_par_q <= (vs_rise | hs_rise) ? 1'b0
                 : pix_par_q ^ cap_q[24];
    end
  end
  wire logic [1:0] dth = {lin_par_q ^ frm_par_q, pix_par_q ^ frm_par_q};

  // Rounds a component to six bits with the dither offset
  function automatic logic [7:0] dith8(input logic [7:0] c,
                                       input logic [1:0] t);
    logic [8:0] s;
    s = {1'b0, c} + {7'h0, t};
    dith8 = s[8] ? 8'hfc : {s[7:2], 2'h0};
  endfunction : dith8

  // Colour path: dither or width cut, then link word assembly
  wire logic       dith_en = ctrl_q[CTRL_DITH];
  wire logic       cut18   = ctrl_q[CTRL_W18];
  wire logic [7:0] lo_mask = cut18 ? 8'hfc : 8'hff;
  wire logic [7:0] out_r = dith_en ? dith8(lut_r, dth)
                                   : (lut_r & lo_mask);
  wire logic [7:0] out_g = dith_en ? dith8(lut_g, dth) : (lut_g & lo_mask);
  wire logic [7:0] out_b = dith_en ? dith8(lut_b, dth) : (lut_b & lo_mask);
  // Syncs and valid pass untouched
  wire logic [DATA_W-1:0] pay = {cap_q[26:24],
                                 out_r, out_g, out_b};
  wire logic [WORD_W-1:0] word = {SEQ_MARK, ~^pay, pay};

  // Newest processed word waiting for the transmitter
  logic [WORD_W-1:0] pend_q;
  logic              pend_v_q;
  rdls_tx_t          tx_q;
  wire logic load = (tx_q == TX_IDLE) & pend_v_q & run;
  always_ff @(posedge clk_sys) begin
    if (rst || !run) begin
      pend_v_q <= 1'b0;
      pend_q   <= '0;
    end else if (cap_new_q) begin
      pend_v_q <= 1'b1;
      pend_q   <= word;
    end else if (load) begin
      pend_v_q <= 1'b0;
    end
  end

  // Transmitter: bit phase, bit count and gap between words
  logic [WORD_W-1:0] tx_w_q;
  logic [2:0]        ph_q;
  logic [4:0]        bit_q;
  logic              l0_q;
  logic              l1_q;
  logic              lc_q;
  wire  logic [3:0]  bsel = 4'(LANE_BITS - 1) - bit_q[3:0];
  wire  logic        last_ph = (ph_q == 3'(2 * LINK_HALF - 1));
  always_ff @(posedge clk_sys) begin
    if (rst || !run) begin
      tx_q  <= TX_IDLE;
      tx_w_q <= '0;
      ph_q  <= '0;
      bit_q <= '0;
      {l0_q, l1_q, lc_q} <= 3'h0;
    end else begin
      unique case (tx_q)
        TX_IDLE: begin
          if (load) begin
            tx_q   <= TX_SHIFT;
            tx_w_q <= pend_q;
            ph_q   <= '0;
            bit_q  <= '0;
          end
        end
        TX_SHIFT: begin
          ph_q <= last_ph ? 3'h0 : ph_q + 3'h1;
          lc_q <= (ph_q >= 3'(LINK_HALF - 1)) & ~last_ph;
          if (ph_q == 3'h0) begin
            l0_q <= tx_w_q[16 + bsel];
            l1_q <= tx_w_q[bsel];
          end
          if (last_ph) begin
            bit_q <= bit_q + 5'h1;
            if (bit_q == 5'(LANE_BITS - 1)) begin
              tx_q <= TX_GAP;
              ph_q <= '0;
            end
          end
        end
        TX_GAP: begin
          lc_q <= 1'b0;
          ph_q <= ph_q + 3'h1;
          if (ph_q == 3'(LINK_GAP - 1))
            tx_q <= TX_IDLE;
        end
        default: tx_q <= TX_IDLE;
      endcase
    end
  end

  // Differential outputs; both legs low while asleep
  assign link.lane0_diff_out      = run ? {l0_q, ~l0_q} : 2'h0;
  assign link.lane1_diff_out      = run ? {l1_q, ~l1_q} : 2'h0;
  assign link.link_clock_diff_out = run ? {lc_q, ~lc_q} : 2'h0;
endmodule : rdls_serializer

/* testbench/rdls_link_sva.sv */
// Wire checker for the link between serializer and receiver
`timescale 1ns/1ps
module rdls_link_sva
  import rdls_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [1:0] lane0_diff_out,
  input wire logic [1:0] lane1_diff_out,
  input wire logic [1:0] link_clock_diff_out,
  input wire logic       cfg_port_select_n,
  input wire logic       cfg_port_clk,
  input wire logic       cfg_port_in,
  input wire logic       sleep_request_n,
  input wire logic       test_select
);
  localparam int SEL_CYC = CFG_W * CFG_HALF * 2;
  logic       lc_q, cc_q;
  logic [7:0] gap_q, scnt_q;
  logic [4:0] bcnt_q, ccnt_q;
  // Edge finders, word start and bit index on the lane clock
  wire logic       lrise  = link_clock_diff_out[1] && !lc_q;
  wire logic       crise  = cfg_port_clk && !cc_q;
  wire logic       wstart = lrise && gap_q > 8'h4;
  wire logic [4:0] bidx   = wstart ? 5'h0 : bcnt_q;
  wire logic       legs_ok = (lane0_diff_out == 2'h0 || ^lane0_diff_out) &&
    (lane1_diff_out == 2'h0 || ^lane1_diff_out) &&
    (link_clock_diff_out == 2'h0 || ^link_clock_diff_out);
  // Gap, bit, select and frame bit counters
  always_ff @(posedge clk_sys) begin
    lc_q   <= !rst && link_clock_diff_out[1];
    cc_q   <= !rst && cfg_port_clk;
    gap_q  <= (rst || lrise) ? 8'h0 : gap_q + {7'h0, gap_q != 8'hff};
    // A quiet pair (any sleep) cuts the word, so the bit count restarts
    bcnt_q <= (rst || link_clock_diff_out == 2'h0) ? 5'h0
              : lrise ? bidx + 5'h1 : bcnt_q;
    scnt_q <= (rst || cfg_port_select_n) ? 8'h0 : scnt_q + 8'h1;
    ccnt_q <= (rst || cfg_port_select_n) ? 5'h0 : ccnt_q + {4'h0, crise};
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_pair_legs: assert property (legs_ok)
    else $error("Link pair legs not complementary");
  a_sleep_quiet: assert property (!sleep_request_n [*6] |->
    {lane0_diff_out, lane1_diff_out, link_clock_diff_out} == 6'h0)
    else $error("Link active while sleep requested");
  a_lclk_high: assert property (
    disable iff (rst || !sleep_request_n || link_clock_diff_out == 2'h0)
    $rose(link_clock_diff_out[1]) |->
    ##1 link_clock_diff_out[1] ##1 !link_clock_diff_out[1])
    else $error("Lane clock high phase not two cycles");
  a_word_bits: assert property (disable iff (rst || test_select)
    wstart && bcnt_q != 5'h0 |-> bcnt_q == LANE_BITS)
    else $error("Word bit count wrong");
  a_word_mark: assert property (lrise && bidx < 5'h4 |->
    lane0_diff_out[1] == SEQ_MARK[2'h3 - bidx[1:0]])
    else $error("Sequence mark bit wrong");
  a_frame_bits: assert property ($rose(cfg_port_select_n) |->
    ccnt_q == CFG_W)
    else $error("Config frame bit count wrong");
  a_select_len: assert property ($rose(cfg_port_select_n) |->
    scnt_q == SEL_CYC)
    else $error("Config select low time wrong");
  a_cfg_clk_high: assert property ($rose(cfg_port_clk) |->
    cfg_port_clk [*4] ##1 !cfg_port_clk)
    else $error("Config clock high phase wrong");
  a_cfg_hold: assert property (
    cfg_port_clk |-> $stable(cfg_port_in))
    else $error("Config data moved while clock high");
  a_cfg_idle: assert property (
    cfg_port_select_n |-> !cfg_port_clk)
    else $error("Config clock runs while deselected");
  c_word: cover property (wstart && bcnt_q == LANE_BITS);
  c_frame: cover property ($rose(cfg_port_select_n) && ccnt_q == CFG_W);
  c_sleep: cover property (!sleep_request_n [*6]);
endmodule : rdls_link_sva

/* testbench/test_rgb_display_link_serializer.sv */
// Self-checking bench for the serializer and receiver pair
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("Error t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_rgb_display_link_serializer
  import rdls_pkg::*;
();
  logic        clk_sys, rst, pixel_clk, pclk_run, read, write;
  logic        frame_sync, line_sync, pixel_valid;
  logic        waitrequest, asleep, rx_pixel_valid;
  logic [1:0]  pdiv;
  logic [4:0]  address;
  logic [7:0]  red_in, green_in, blue_in;
  logic [26:0] rx_pixel;
  logic [31:0] writedata, readdata, v;
  int          failures, checked;
  rdls_link_if link_if ();
  rdls_serializer #(.STOP_CYCLES(100)) i_rdls_serializer (
    .clk_sys(clk_sys), .rst(rst), .pixel_clk(pixel_clk), .red_in(red_in),
    .green_in(green_in), .blue_in(blue_in), .frame_sync(frame_sync),
    .line_sync(line_sync), .pixel_valid(pixel_valid), .asleep(asleep),
    .link(link_if.dev));
  rdls_receiver i_rdls_receiver (
    .clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rx_pixel(rx_pixel),
    .rx_pixel_valid(rx_pixel_valid), .link(link_if.host));
  rdls_link_sva i_rdls_link_sva (
    .clk_sys(clk_sys), .rst(rst),
    .lane0_diff_out(link_if.lane0_diff_out),
    .lane1_diff_out(link_if.lane1_diff_out),
    .link_clock_diff_out(link_if.link_clock_diff_out),
    .cfg_port_select_n(link_if.cfg_port_select_n),
    .cfg_port_clk(link_if.cfg_port_clk), .cfg_port_in(link_if.cfg_port_in),
    .sleep_request_n(link_if.sleep_request_n),
    .test_select(link_if.test_select));
  // System clock, and a 320 ns pixel clock that can be stopped
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    pdiv <= pdiv + 2'h1;
    if (pclk_run && pdiv == 2'h3)
      pixel_clk <= ~pixel_clk;
  end
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    {address, writedata, read, write} <= {a, d, !wr, wr};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 400);
    if (n >= 400)
      failures++;
    v = readdata;
    {read, write} <= 2'h0;
  endtask : bus
  // Send one configuration frame and wait for the port to go idle
  task automatic cfg(input logic [1:0] t, input logic [7:0] i, d);
    int n;
    bus(1'b1, A_CMD, {14'h0, t, i, d});
    n = 0;
    do begin
      bus(1'b0, A_STATUS, 32'h0);
      n++;
    end while (v[0] !== 1'b0 && n < 100);
    `CHK(v[0], 1'b0)
  endtask : cfg
  // Let three words arrive so the newest pixel has crossed
  task automatic settle();
    int n, k;
    {n, k} = 64'h0;
    while (k < 3 && n < 900) begin
      @(negedge clk_sys);
      n++;
      k += (rx_pixel_valid === 1'b1);
    end
    if (k < 3)
      failures++;
  endtask : settle
  // Collect both data lanes at the sixteen lane clock rises of a word
  task automatic cap(output logic [31:0] w);
    int q, n;
    logic p;
    {q, n, w} = 96'h0;
    while (q < 6 && n < 400) begin
      @(negedge clk_sys);
      n++;
      q = link_if.link_clock_diff_out[1] ? 0 : q + 1;
    end
    for (int b = 0; b < LANE_BITS; b++) begin
      n = 0;
      do begin
        p = link_if.link_clock_diff_out[1];
        @(negedge clk_sys);
        n++;
      end while ((p || !link_if.link_clock_diff_out[1]) && n < 20);
      w[31 - b] = link_if.lane0_diff_out[1];
      w[15 - b] = link_if.lane1_diff_out[1];
    end
  endtask : cap
  // Present a pixel, then judge the received word and the wire word
  task automatic pix(input logic [7:0] r, g, b, input logic [2:0] s,
                     input logic [26:0] e);
    logic [31:0] w;
    @(posedge clk_sys);
    {frame_sync, line_sync, pixel_valid, red_in, green_in, blue_in} <=
      {s, r, g, b};
    settle();
    `CHK(rx_pixel, e)
    cap(w);
    `CHK(w, {SEQ_MARK, ~^e, e})
  endtask : pix
  // Power register reset value and an unmapped place
  task automatic t_regs();
    bus(1'b0, A_POWER, 32'h0);
    `CHK(v, {30'h0, POWER_RST})
    bus(1'b1, 5'h1c, 32'hffffffff);
    bus(1'b0, 5'h1c, 32'h0);
    `CHK(v, 32'h0)
  endtask : t_regs
  // Default settings pass colours and syncs untouched
  task automatic t_plain();
    pix(8'h81, 8'h42, 8'h24, 3'h5, {3'h5, 24'h814224});
    bus(1'b0, A_PIXEL, 32'h0);
    `CHK(v[26:0], {3'h5, 24'h814224})
    pix(8'h00, 8'hff, 8'h7e, 3'h2, {3'h2, 24'h00ff7e});
  endtask : t_plain
  // Narrow width drops the two low colour bits
  task automatic t_width();
    cfg(TGT_CTRL, 8'h0, 8'h04);
    pix(8'h81, 8'h42, 8'h27, 3'h5, {3'h5, 24'h804024});
  endtask : t_width
  // Stopped pixel clock sleeps and keeps the settings
  task automatic t_stop();
    pclk_run <= 1'b0;
    repeat (150) @(negedge clk_sys);
    `CHK(asleep, 1'b1)
    pclk_run <= 1'b1;
    pix(8'h81, 8'h42, 8'h27, 3'h5, {3'h5, 24'h804024});
    `CHK(asleep, 1'b0)
  endtask : t_stop
  // Table entries at both index ends, then lookup ahead of dither
  task automatic t_table();
    cfg(TGT_RED, 8'h81, 8'h3c);
    cfg(TGT_GRN, 8'h00, 8'hc0);
    cfg(TGT_BLU, 8'hff, 8'h14);
    cfg(TGT_CTRL, 8'h0, 8'h01);
    pix(8'h81, 8'h00, 8'hff, 3'h7, {3'h7, 24'h3cc014});
    cfg(TGT_CTRL, 8'h0, 8'h03);
    pix(8'h81, 8'h00, 8'hff, 3'h5, {3'h5, 24'h3cc014});
    pix(8'h81, 8'h00, 8'hff, 3'h1, {3'h1, 24'h3cc014});
    cfg(TGT_CTRL, 8'h0, 8'h02);
    settle();
    `CHK({rx_pixel[17:16], rx_pixel[9:8], rx_pixel[1:0]}, 6'h0)
    bus(1'b0, A_STATUS, 32'h0);
    `CHK(v[1], 1'b1)
    bus(1'b0, A_ERRS, 32'h0);
    `CHK(v[15:0], 16'h0)
  endtask : t_table
  // Test select quiets the link; sleep pin clears control, keeps tables
  task automatic t_pin();
    bus(1'b1, A_POWER, 32'h3);
    repeat (8) @(negedge clk_sys);
    `CHK(asleep, 1'b1)
    bus(1'b1, A_POWER, 32'h0);
    repeat (8) @(negedge clk_sys);
    `CHK(asleep, 1'b1)
    cfg(TGT_RED, 8'h81, 8'h55);
    bus(1'b1, A_POWER, 32'h1);
    pix(8'h81, 8'h42, 8'h27, 3'h5, {3'h5, 24'h814227});
    cfg(TGT_CTRL, 8'h0, 8'h01);
    pix(8'h81, 8'h00, 8'hff, 3'h7, {3'h7, 24'h3cc014});
  endtask : t_pin
  // Verdict and end of run
  task automatic close_out();
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    {rst, pclk_run, pixel_clk, frame_sync, line_sync, pixel_valid} = 6'h30;
    {read, write, pdiv, address, writedata} = 41'h0;
    {red_in, green_in, blue_in} = 24'h0;
    {failures, checked} = 64'h0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_plain();
    t_width();
    t_stop();
    t_table();
    t_pin();
    close_out();
  end
  // Watchdog
  initial begin
    #800000;
    failures++;
    close_out();
  end
endmodule : test_rgb_display_link_serializer
